/* File: hw/switch_timeout_error_reporting.sv */
// time-out discard status, severity reporting and counters behind apb
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module switch_timeout_error_reporting #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              porRstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0]        queueExpired,
    output logic [3:0]             queueDiscard,
    output logic                   errCorMsg,
    output logic                   errNonfatalMsg,
    output logic                   errFatalMsg,
    output logic                   irq
);

    if (ADDR_W < 12)
    begin : g_check
        $error("ADDR_W must be at least 12");
    end

    typedef struct packed {
        logic        enable;
        logic [3:0]  status;
        logic [7:0]  severity;
        logic [31:0] counters;
        logic [3:0]  irqStat;
        logic [3:0]  irqMask;
        logic [3:0]  discard;
        logic        errCor;
        logic        errNonfatal;
        logic        errFatal;
        logic        irq;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        ack;
    } state_t;

    state_t st;
    state_t next_st;

    logic [11:0] addr;
    assign addr = paddr[11:0];

    always_comb
    begin
        logic        access;
        logic        capture;
        logic        commit;
        logic        hit;
        logic        readCnt;
        logic        readIrq;
        logic [3:0]  events;
        logic [3:0]  w1c;
        logic [3:0]  rise;
        logic [7:0]  base;
        logic [1:0]  sev;
        logic [31:0] rmux;
        next_st = st;
        access  = psel & penable;
        capture = access & ~st.ack;
        commit  = access & st.ack & pwrite;
        hit     = 1'b0;
        rmux    = 32'h0000_0000;
        rise    = 4'h0;
        base    = 8'h00;
        sev     = 2'b00;
        case (addr)
            sw_timeout_pkg::OFF_CONTROL:
            begin
                hit  = 1'b1;
                rmux = {31'h0000_0000, st.enable};
            end
            sw_timeout_pkg::OFF_STATUS:
            begin
                hit  = 1'b1;
                rmux = {28'h000_0000, st.status};
            end
            sw_timeout_pkg::OFF_SEVERITY:
            begin
                hit  = 1'b1;
                rmux = {24'h00_0000, st.severity};
            end
            sw_timeout_pkg::OFF_COUNTERS:
            begin
                hit  = 1'b1;
                rmux = st.counters;
            end
            sw_timeout_pkg::OFF_IRQ_STAT:
            begin
                hit  = 1'b1;
                rmux = {28'h000_0000, st.irqStat};
            end
            sw_timeout_pkg::OFF_IRQ_MASK:
            begin
                hit  = 1'b1;
                rmux = {28'h000_0000, st.irqMask};
            end
            default:
            begin
                hit  = 1'b0;
                rmux = 32'h0000_0000;
            end
        endcase
        // upper address bits must be zero; avoids a zero-width replication at 12 bits
        if ((paddr >> 12) != '0)
        begin
            hit = 1'b0;
        end

        // one wait state: outputs are registered, so data is ready a cycle late
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
        if (capture)
        begin
            next_st.ack    = 1'b1;
            next_st.ready  = 1'b1;
            next_st.slverr = ~hit;
            if (!pwrite)
            begin
                next_st.rdata = hit ? rmux : 32'h0000_0000;
            end
        end
        else
        begin
            next_st.ack = 1'b0;
        end
        // read-clear at the capture edge so no discard slips between sample and clear
        readCnt = capture & ~pwrite & hit & (addr == sw_timeout_pkg::OFF_COUNTERS);
        readIrq = capture & ~pwrite & hit & (addr == sw_timeout_pkg::OFF_IRQ_STAT);

        next_st.discard = queueExpired & {4{st.enable}};
        events = st.discard;

        w1c = 4'h0;
        if (commit && hit)
        begin
            case (addr)
                sw_timeout_pkg::OFF_CONTROL:
                begin
                    next_st.enable = pwdata[0];
                end
                sw_timeout_pkg::OFF_STATUS:
                begin
                    w1c = pwdata[3:0];
                end
                sw_timeout_pkg::OFF_SEVERITY:
                begin
                    next_st.severity = pwdata[7:0];
                end
                sw_timeout_pkg::OFF_IRQ_MASK:
                begin
                    next_st.irqMask = pwdata[3:0];
                end
                default:
                begin
                    w1c = 4'h0;
                end
            endcase
        end
        // set wins over a same-cycle clear
        next_st.status = (st.status & ~w1c) | events;

        for (int i = 0; i < 4; i++)
        begin
            base = readCnt ? 8'h00 : st.counters[i*8 +: 8];
            if (events[i] && base != 8'hFF)
            begin
                base = base + 8'h01;
            end
            next_st.counters[i*8 +: 8] = base;
        end

        next_st.irqStat = (readIrq ? 4'h0 : st.irqStat) | events;

        rise = next_st.status & ~st.status;
        next_st.errCor      = 1'b0;
        next_st.errNonfatal = 1'b0;
        next_st.errFatal    = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            sev = st.severity[i*2 +: 2];
            if (rise[i])
            begin
                case (sev)
                    sw_timeout_pkg::SEV_COR:      next_st.errCor      = 1'b1;
                    sw_timeout_pkg::SEV_NONFATAL: next_st.errNonfatal = 1'b1;
                    sw_timeout_pkg::SEV_FATAL:    next_st.errFatal    = 1'b1;
                    default:                      next_st.errCor      = next_st.errCor;
                endcase
            end
        end

        next_st.irq = |(next_st.irqStat & next_st.irqMask);

        // port reset spares the sticky severity, counters and enable
        if (!porRstn)
        begin
            next_st = '0;
            next_st.enable   = sw_timeout_pkg::RST_ENABLE;
            next_st.severity = sw_timeout_pkg::RST_SEVERITY;
            next_st.counters = sw_timeout_pkg::RST_COUNTERS;
            next_st.status   = sw_timeout_pkg::RST_STATUS;
            next_st.irqMask  = sw_timeout_pkg::RST_IRQ_MASK;
        end
        else if (!rstn)
        begin
            next_st.status      = sw_timeout_pkg::RST_STATUS;
            next_st.irqStat     = 4'h0;
            next_st.irqMask     = sw_timeout_pkg::RST_IRQ_MASK;
            next_st.discard     = 4'h0;
            next_st.errCor      = 1'b0;
            next_st.errNonfatal = 1'b0;
            next_st.errFatal    = 1'b0;
            next_st.irq         = 1'b0;
            next_st.rdata       = 32'h0000_0000;
            next_st.ready       = 1'b0;
            next_st.slverr      = 1'b0;
            next_st.ack         = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign prdata         = st.rdata;
    assign pready         = st.ready;
    assign pslverr        = st.slverr;
    assign queueDiscard   = st.discard;
    assign errCorMsg      = st.errCor;
    assign errNonfatalMsg = st.errNonfatal;
    assign errFatalMsg    = st.errFatal;
    assign irq            = st.irq;

endmodule : switch_timeout_error_reporting

`default_nettype wire

/* File: hw/sw_timeout_pkg.sv */
// constants for the switch time-out error reporting register bank
// What this block does
// - posted queue discard sets status bit 0
// - non-posted queue discard sets status bit 1
// - completion queue discard sets status bit 2
// - insertion queue discard sets status bit 3
// - severity 0 none, 1 cor, 2 nonfatal, 3 fatal
// - message only on flag zero-to-one edge
// - posted severity bits 1:0, resets to 2
// - non-posted severity bits 3:2, resets to 0
// - completion severity bits 5:4, resets to 0
// - insertion severity bits 7:6, resets to 2
// - posted counter bits 7:0 counts discards
// - non-posted counter bits 15:8 counts discards
// - completion counter bits 23:16 counts discards
// - insertion counter bits 31:24 counts discards
// - counters saturate at all ones
// - counter read returns value then clears
// - enabled port discards expired queued packets
`default_nettype none
package sw_timeout_pkg;

    localparam int unsigned NUM_QUEUES = 4;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned SEV_W      = 2;

    localparam logic [11:0] OFF_CONTROL  = 12'h0750;
    localparam logic [11:0] OFF_STATUS   = 12'h0754;
    localparam logic [11:0] OFF_SEVERITY = 12'h0758;
    localparam logic [11:0] OFF_COUNTERS = 12'h075C;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h0770;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h0774;

    // queue index doubles as status bit position
    localparam int unsigned Q_POSTED     = 0;
    localparam int unsigned Q_NONPOSTED  = 1;
    localparam int unsigned Q_COMPLETION = 2;
    localparam int unsigned Q_INSERTION  = 3;

    localparam logic        RST_ENABLE   = 1'h1;
    localparam logic [3:0]  RST_STATUS   = 4'h0;
    localparam logic [7:0]  RST_SEVERITY = 8'h82;
    localparam logic [31:0] RST_COUNTERS = 32'h0000_0000;
    localparam logic [3:0]  RST_IRQ_MASK = 4'h0;

    typedef enum logic [1:0] {
        SEV_NONE     = 2'b00,
        SEV_COR      = 2'b01,
        SEV_NONFATAL = 2'b10,
        SEV_FATAL    = 2'b11
    } severity_t;

endpackage : sw_timeout_pkg

`default_nettype wire

/* File: dv/sw_timeout_er_asserts.sv */
// assertion checker for the time-out reporting bank
`timescale 1ns/1ps
`default_nettype none
module sw_timeout_er_asserts #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              porRstn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [3:0]        queueExpired,
    input wire logic [3:0]        queueDiscard,
    input wire logic              errCorMsg,
    input wire logic              errNonfatalMsg,
    input wire logic              errFatalMsg,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!porRstn || !rstn);
    logic rdDone;
    logic anyDisc;
    logic anyMsg;
    assign rdDone = pready && !pwrite;
    assign anyDisc = |queueDiscard;
    assign anyMsg = errCorMsg || errNonfatalMsg || errFatalMsg;
    disc_cause_a: assert property ((queueDiscard & ~$past(queueExpired)) == 4'h0)
        else $error("discard without expiry");
    msg_cause_a: assert property (anyMsg |-> $past(anyDisc))
        else $error("message without discard");
    ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access not answered after one wait");
    ready_solo_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused access returned data");
    sts_rsvd_a: assert property (rdDone && paddr == sw_timeout_pkg::OFF_STATUS
        |-> prdata[31:4] == 28'h000_0000) else $error("status upper bits set");
    sev_rsvd_a: assert property (rdDone && paddr == sw_timeout_pkg::OFF_SEVERITY
        |-> prdata[31:8] == 24'h00_0000) else $error("severity upper bits set");
    rd_hold_a: assert property (!$stable(prdata) |-> rdDone)
        else $error("read data moved outside a read");
    cover property (errFatalMsg);
    cover property (pready && pslverr);
    cover property (irq);
endmodule : sw_timeout_er_asserts

bind switch_timeout_error_reporting sw_timeout_er_asserts #(.ADDR_W(ADDR_W)) assertsInst (.*);
`default_nettype wire

/* File: dv/sw_timeout_root_model.sv */
// queue heads that expire on command, and a root that counts error messages
`timescale 1ns/1ps
`default_nettype none
module sw_timeout_root_model (
    input  wire logic       clk,
    input  wire logic       porRstn,
    input  wire logic [3:0] go,
    output logic      [3:0] queueExpired,
    input  wire logic       errCorMsg,
    input  wire logic       errNonfatalMsg,
    input  wire logic       errFatalMsg,
    output int              corSeen,
    output int              nonfatalSeen,
    output int              fatalSeen
);
    // each held cycle of go is one expired head packet
    always_ff @(posedge clk)
    begin
        queueExpired <= porRstn ? go : 4'h0;
        corSeen <= porRstn ? corSeen + int'(errCorMsg) : 0;
        nonfatalSeen <= porRstn ? nonfatalSeen + int'(errNonfatalMsg) : 0;
        fatalSeen <= porRstn ? fatalSeen + int'(errFatalMsg) : 0;
    end
endmodule : sw_timeout_root_model
`default_nettype wire

/* File: dv/tb_switch_timeout_error_reporting.sv */
// register, event and reset sequences for the time-out reporting bank
`timescale 1ns/1ps
`default_nettype none
module tb_switch_timeout_error_reporting;
    localparam logic [11:0] EN = sw_timeout_pkg::OFF_CONTROL;
    localparam logic [11:0] ST = sw_timeout_pkg::OFF_STATUS;
    localparam logic [11:0] SV = sw_timeout_pkg::OFF_SEVERITY;
    localparam logic [11:0] CN = sw_timeout_pkg::OFF_COUNTERS;
    logic        clk = 1'b0, rstn = 1'b0, porRstn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, rdErr, irq, errCorMsg, errNonfatalMsg, errFatalMsg;
    logic [3:0]  go = 4'h0, queueExpired, queueDiscard;
    int          corSeen, nonfatalSeen, fatalSeen, badCount = 0, samplesChecked = 0;
    always #25 clk = ~clk;
    switch_timeout_error_reporting switch_timeout_error_reporting_inst (.*);
    sw_timeout_root_model sw_timeout_root_model_inst (.*);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic endOfTest;
        $display("compares %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : endOfTest
    // holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge clk);
        if (pready !== 1'b1)
        begin
            badCount++;
            endOfTest();
        end
        {rd, rdErr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask : rdChk
    task automatic fire(input logic [3:0] m, input int n);
        @(posedge clk);
        go <= m;
        repeat (n) @(posedge clk);
        go <= 4'h0;
        repeat (4) @(posedge clk);
    endtask : fire
    initial
    begin
        repeat (12) @(posedge clk);
        {rstn, porRstn} <= 2'b11;
        rdChk("status", ST, 32'h0000_0000);
        rdChk("severity", SV, 32'h0000_0082);
        rdChk("counters", CN, 32'h0000_0000);
        rdChk("enable", EN, 32'h0000_0001);
        rdChk("unmapped", 12'h780, 32'h0000_0000);
        chk("slverr", {31'h0, rdErr}, 32'h0000_0001);
        fire(4'h1, 1);
        fire(4'h1, 1);
        chk("nonfatal", nonfatalSeen, 32'h0000_0001);
        apb(1'b1, ST, 32'h0000_0000);
        rdChk("status", ST, 32'h0000_0001);
        apb(1'b1, ST, 32'h0000_000F);
        rdChk("status", ST, 32'h0000_0000);
        apb(1'b1, SV, 32'h0000_00E4);
        fire(4'hF, 1);
        rdChk("status", ST, 32'h0000_000F);
        chk("cor", corSeen, 32'h0000_0001);
        chk("nonfatal", nonfatalSeen, 32'h0000_0002);
        rdChk("counters", CN, 32'h0101_0103);
        rdChk("counters", CN, 32'h0000_0000);
        fire(4'h8, 300);
        chk("fatal", fatalSeen, 32'h0000_0001);
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) rstn <= 1'b1;
        rdChk("severity", SV, 32'h0000_00E4);
        rdChk("counters", CN, 32'h FF00_0000);
        rdChk("status", ST, 32'h0000_0000);
        fire(4'h1, 1);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, sw_timeout_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        fire(4'h1, 1);
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        rdChk("irqstat", sw_timeout_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, EN, 32'h0000_0000);
        apb(1'b1, ST, 32'h0000_000F);
        fire(4'h1, 1);
        rdChk("status", ST, 32'h0000_0000);
        endOfTest();
    end
endmodule : tb_switch_timeout_error_reporting
`default_nettype wire
